// ### cfm_params.svh
`ifndef CFM_PARAMS_SVH
`define CFM_PARAMS_SVH
// Notes on behaviour
// RULE_01: frame type selector, default classic base data
// RULE_02: relational identifier operators use minimum pattern only
// RULE_03: identifier maximum used only for range operators
// RULE_04: standard format decides at IDE sample point
// RULE_05: extended format decides at RTR sample point
// RULE_06: any format ignores identifier format and pattern
// RULE_07: no remote frame matching for FD frames
// RULE_08: form error trigger when its enable set
// RULE_09: stuff count error trigger when enable set
// RULE_10: acknowledge error when slot stays recessive
// RULE_11: sixth equal bit in stuffed fields triggers
// RULE_12: computed CRC differing from received CRC triggers
// RULE_13: error enables act only in error type, reset on
// RULE_14: bit rate switch match one/zero/dont-care, default one
// RULE_15: error state indicator match, default dont-care
// RULE_16: acceptance field eight operators, default equal
// RULE_17: acceptance field maximum only for range operators
// RULE_18: service data unit type eight operators
// RULE_19: simple extended content bit match, default dont-care
// RULE_20: virtual CAN identifier eight operators
// RULE_21: frame start type triggers on SOF edge, default
// RULE_22: one-cycle strobe, partial state cleared per frame
// RULE_23: range bounds inclusive, out-of-range excludes interval

// ==========================================================
// register byte offsets
`define CFM_ADDR_CFG     8'h00
`define CFM_ADDR_ID_MIN  8'h04
`define CFM_ADDR_ID_MAX  8'h08
`define CFM_ADDR_AF_MIN  8'h0c
`define CFM_ADDR_AF_MAX  8'h10
`define CFM_ADDR_XL_PAT  8'h14
`define CFM_ADDR_STATUS  8'h18

// ==========================================================
// configuration word layout and reset value
`define CFM_CFG_RESET    32'h0051f000
`define CFM_ERR_LSB      12
`define CFM_ERR_N        5
`define CFM_ID_BITS      29
`define CFM_STUFF_LIMIT  3'h6
`define CFM_CRC_BITS     15
`define CFM_CRC_POLY     15'h4599
`define CFM_CRC_CNT_W    5
`define CFM_CRC_SEQ_LEN  5'h0f
`endif

// ### cfm_pkg.sv
package cfm_pkg;
    // trigger types
    typedef enum logic [2:0] {
        frame_start_type, frame_type_type, ident_type, error_condition_type
    } cfm_trig_t;
    // frame type selector and decoder frame kind
    typedef enum logic [3:0] {
        classic_base_data_frame, classic_base_remote_frame,
        classic_extended_data_frame, classic_extended_remote_frame,
        fd_base_frame, fd_extended_frame, xl_frame, error_frame, overload_frame
    } cfm_ftype_t;
    // compare operators
    typedef enum logic [2:0] {
        equal_operator, not_equal_operator, less_than_operator, less_or_equal_operator,
        greater_than_operator, greater_or_equal_operator, in_range_operator,
        out_of_range_operator
    } cfm_op_t;
    typedef enum logic [1:0] {
        standard_identifier_format, extended_identifier_format, any_identifier_format
    } cfm_fmt_t;
    typedef enum logic [1:0] {one_value, zero_value, dont_care_value} cfm_bit_t;
    // configuration word
    typedef struct packed {
        cfm_op_t    vcidOp;         // 31:29
        cfm_op_t    sdtOp;          // 28:26
        cfm_op_t    afOp;           // 25:23
        cfm_bit_t   secMatch;       // 22:21
        cfm_bit_t   esiMatch;       // 20:19
        cfm_bit_t   brsMatch;       // 18:17
        logic [4:0] errEnable;      // 16:12 crc,bitstuff,ack,stuffcnt,form
        cfm_fmt_t   idFormat;       // 11:10
        cfm_op_t    idOp;           // 9:7
        cfm_ftype_t frameSel;       // 6:3
        cfm_trig_t  trigType;       // 2:0
    } cfm_cfg_t;
    // decoder event and field carrier
    typedef struct packed {
        logic        sofEdge;       // first edge of dominant SOF
        logic        ideSample;     // IDE bit sample point
        logic        rtrSample;     // extended RTR bit sample point
        logic        fdCtrlValid;   // brs/esi valid
        logic        xlValid;       // xl fields valid
        logic        errFrame;      // error frame seen
        logic        ovldFrame;     // overload frame seen
        logic        bitValid;      // one sampled bit
        logic        bitValue;
        logic        stuffRegion;   // bit lies in stuffed fields
        logic        crcRegion;     // bit covered by the CRC
        logic        crcSeqBit;     // bit is part of the CRC sequence
        logic        ackSlot;       // acknowledge slot sample
        logic        formBad;       // illegal fixed-form bit
        logic        stuffCntBad;   // FD stuff count mismatch
        cfm_ftype_t  kind;
        logic [28:0] ident;
        logic        brs;
        logic        esi;
        logic [7:0]  sdt;
        logic        sec;
        logic [7:0]  vcid;
        logic [31:0] af;
    } cfm_dec_t;
endpackage

// ### cfm_trigger_matcher.sv
// Implementation choices: the register addresses and the Wishbone register port.
`include "cfm_params.svh"

module cfm_trigger_matcher (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             clkEn,
    input  wire cfm_pkg::cfm_dec_t dec,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    output logic                  trigger
);

    // ==========================================================
    // helpers
    // generic compare of a field against its patterns
    function automatic logic cmpOp(input cfm_pkg::cfm_op_t op, input logic [31:0] v,
                                   input logic [31:0] lo, input logic [31:0] hi);
        logic inR;
        inR = (v >= lo) && (v <= hi);                        // [RULE_23]
        case (op)
            cfm_pkg::equal_operator:            cmpOp = (v == lo);   // [RULE_02]
            cfm_pkg::not_equal_operator:        cmpOp = (v != lo);
            cfm_pkg::less_than_operator:        cmpOp = (v < lo);
            cfm_pkg::less_or_equal_operator:    cmpOp = (v <= lo);
            cfm_pkg::greater_than_operator:     cmpOp = (v > lo);
            cfm_pkg::greater_or_equal_operator: cmpOp = (v >= lo);
            cfm_pkg::in_range_operator:         cmpOp = inR;         // [RULE_03]
            cfm_pkg::out_of_range_operator:     cmpOp = !inR;        // [RULE_23]
            default:                            cmpOp = 1'b0;
        endcase
    endfunction

    // one/zero/dont-care bit match
    function automatic logic bitOk(input cfm_pkg::cfm_bit_t m, input logic b);
        case (m)
            cfm_pkg::one_value:  bitOk = b;
            cfm_pkg::zero_value: bitOk = !b;
            default:             bitOk = 1'b1;
        endcase
    endfunction

    // byte-lane write merge
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] sel);
        wmerge = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                wmerge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction

    // ==========================================================
    // register file
    logic [31:0]       cfgRaw_q, cfgRaw_d;
    logic [31:0]       idMin_q, idMin_d, idMax_q, idMax_d;
    logic [31:0]       afMin_q, afMin_d, afMax_q, afMax_d;
    logic [31:0]       xlPat_q, xlPat_d;
    logic [31:0]       rdat_q, rdat_d;
    logic              ack_q, ack_d;
    logic [15:0]       trigCnt_q, trigCnt_d;
    logic [4:0]        lastCause_q, lastCause_d;
    cfm_pkg::cfm_cfg_t cfg;
    logic              wbReq;
    logic              wbWr;

    assign cfg   = cfm_pkg::cfm_cfg_t'(cfgRaw_q);
    assign wbReq = wb_cyc_i && wb_stb_i && !ack_q;
    assign wbWr  = wbReq && wb_we_i;

    // bus decode, writes and read data
    always_comb begin
        cfgRaw_d = cfgRaw_q;
        idMin_d  = idMin_q;
        idMax_d  = idMax_q;
        afMin_d  = afMin_q;
        afMax_d  = afMax_q;
        xlPat_d  = xlPat_q;
        rdat_d   = rdat_q;
        ack_d    = wbReq;                               // one wait, then ack
        if (wbReq) begin
            case (wb_adr_i)
                `CFM_ADDR_CFG:    rdat_d = cfgRaw_q;
                `CFM_ADDR_ID_MIN: rdat_d = idMin_q;
                `CFM_ADDR_ID_MAX: rdat_d = idMax_q;
                `CFM_ADDR_AF_MIN: rdat_d = afMin_q;
                `CFM_ADDR_AF_MAX: rdat_d = afMax_q;
                `CFM_ADDR_XL_PAT: rdat_d = xlPat_q;
                `CFM_ADDR_STATUS: rdat_d = {11'h000, lastCause_q, trigCnt_q};
                default:          rdat_d = 32'h00000000;   // unmapped reads zero
            endcase
        end
        if (wbWr) begin
            case (wb_adr_i)
                `CFM_ADDR_CFG:    cfgRaw_d = wmerge(cfgRaw_q, wb_dat_i, wb_sel_i); // [RULE_01]
                `CFM_ADDR_ID_MIN: idMin_d  = wmerge(idMin_q, wb_dat_i, wb_sel_i);
                `CFM_ADDR_ID_MAX: idMax_d  = wmerge(idMax_q, wb_dat_i, wb_sel_i);
                `CFM_ADDR_AF_MIN: afMin_d  = wmerge(afMin_q, wb_dat_i, wb_sel_i);
                `CFM_ADDR_AF_MAX: afMax_d  = wmerge(afMax_q, wb_dat_i, wb_sel_i);
                `CFM_ADDR_XL_PAT: xlPat_d  = wmerge(xlPat_q, wb_dat_i, wb_sel_i);
                default:          ;                        // read-only or unmapped
            endcase
        end
    end

    // register the bus side
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfgRaw_q <= `CFM_CFG_RESET;                    // [RULE_13] [RULE_14] [RULE_15]
            idMin_q  <= 32'h00000000;
            idMax_q  <= 32'h00000000;
            afMin_q  <= 32'h00000000;
            afMax_q  <= 32'h00000000;
            xlPat_q  <= 32'h00000000;
            rdat_q   <= 32'h00000000;
            ack_q    <= 1'b0;
        end else if (clkEn) begin
            cfgRaw_q <= cfgRaw_d;
            idMin_q  <= idMin_d;
            idMax_q  <= idMax_d;
            afMin_q  <= afMin_d;
            afMax_q  <= afMax_d;
            xlPat_q  <= xlPat_d;
            rdat_q   <= rdat_d;
            ack_q    <= ack_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ==========================================================
    // bit-level error detectors
    logic [2:0]                  run_q, run_d;
    logic                        lastBit_q, lastBit_d;
    logic [`CFM_CRC_BITS-1:0]    crc_q, crc_d, rxCrc_q, rxCrc_d;
    logic [`CFM_CRC_CNT_W-1:0]   crcCnt_q, crcCnt_d;
    logic                        stuffHit;
    logic                        crcHit;
    logic                        fb;

    // stuff run counter, crc generator and received crc
    always_comb begin
        run_d     = run_q;
        lastBit_d = lastBit_q;
        crc_d     = crc_q;
        rxCrc_d   = rxCrc_q;
        crcCnt_d  = crcCnt_q;
        stuffHit  = 1'b0;
        fb        = dec.bitValue ^ crc_q[`CFM_CRC_BITS-1];
        if (dec.sofEdge) begin                             // [RULE_22]
            run_d     = 3'h1;
            lastBit_d = 1'b0;
            crc_d     = '0;
            rxCrc_d   = '0;
            crcCnt_d  = '0;
        end else if (dec.bitValid) begin
            if (dec.stuffRegion) begin
                lastBit_d = dec.bitValue;
                if (dec.bitValue == lastBit_q && run_q != `CFM_STUFF_LIMIT) begin
                    run_d = run_q + 3'h1;
                    stuffHit = (run_d == `CFM_STUFF_LIMIT);   // [RULE_11]
                end else if (dec.bitValue != lastBit_q) begin
                    run_d = 3'h1;
                end
            end
            if (dec.crcRegion) begin                       // [RULE_12]
                crc_d = {crc_q[`CFM_CRC_BITS-2:0], 1'b0} ^ (fb ? `CFM_CRC_POLY : '0);
            end
            if (dec.crcSeqBit) begin
                rxCrc_d  = {rxCrc_q[`CFM_CRC_BITS-2:0], dec.bitValue};
                crcCnt_d = crcCnt_q + 5'h01;
            end
        end
    end

    // crc mismatch checked at the ack slot once the full sequence arrived
    assign crcHit = dec.ackSlot && (crcCnt_q == `CFM_CRC_SEQ_LEN) && (crc_q != rxCrc_q);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            run_q     <= 3'h0;
            lastBit_q <= 1'b0;
            crc_q     <= '0;
            rxCrc_q   <= '0;
            crcCnt_q  <= '0;
        end else if (clkEn) begin
            run_q     <= run_d;
            lastBit_q <= lastBit_d;
            crc_q     <= crc_d;
            rxCrc_q   <= rxCrc_d;
            crcCnt_q  <= crcCnt_d;
        end
    end

    // ==========================================================
    // error sources gated by their enables
    logic [`CFM_ERR_N-1:0] errEvt;
    logic [`CFM_ERR_N-1:0] errGated;
    logic                  errHit;

    assign errEvt = {crcHit,                                        // [RULE_12]
                     stuffHit,                                      // [RULE_11]
                     dec.ackSlot && dec.bitValue,                   // [RULE_10]
                     dec.stuffCntBad,                               // [RULE_09]
                     dec.formBad};                                  // [RULE_08]

    // each enable acts only in the error-condition type
    generate
        for (genvar g = 0; g < `CFM_ERR_N; g++) begin : g_err
            assign errGated[g] = errEvt[g] && cfg.errEnable[g] &&
                                 (cfg.trigType == cfm_pkg::error_condition_type); // [RULE_13]
        end
    endgenerate
    assign errHit = |errGated;

    // ==========================================================
    // frame condition matching
    typedef enum logic [2:0] {ST_IDLE, ST_HEADER, ST_FDCTRL, ST_XLFIELDS, ST_DONE} cfm_st_t;
    cfm_st_t    state_q, state_d;
    logic       fired_q, fired_d;
    logic       trig_q, trig_d;
    logic       hdrMode;
    logic       decPoint;
    logic       kindOk;
    logic       idOk;
    logic       fdOk;
    logic       xlOk;
    logic       isFd;

    assign hdrMode = (cfg.trigType == cfm_pkg::frame_type_type) ||
                     (cfg.trigType == cfm_pkg::ident_type);
    // decision point depends on identifier format
    assign decPoint = (cfg.idFormat == cfm_pkg::extended_identifier_format) ?
                      dec.rtrSample : dec.ideSample;                // [RULE_04] [RULE_05]
    assign isFd = (dec.kind == cfm_pkg::fd_base_frame) ||
                  (dec.kind == cfm_pkg::fd_extended_frame);
    // remote selectors only ever meet classic kinds; FD kinds are data only
    assign kindOk = (cfg.trigType != cfm_pkg::frame_type_type) ||
                    (dec.kind == cfg.frameSel);                     // [RULE_01] [RULE_07]
    assign idOk = (cfg.trigType != cfm_pkg::ident_type) ||
                  (cfg.idFormat == cfm_pkg::any_identifier_format) ||  // [RULE_06]
                  cmpOp(cfg.idOp, {3'h0, dec.ident}, idMin_q, idMax_q); // [RULE_02] [RULE_03]
    assign fdOk = bitOk(cfg.brsMatch, dec.brs) && bitOk(cfg.esiMatch, dec.esi); // [RULE_14] [RULE_15]
    assign xlOk = cmpOp(cfg.afOp, dec.af, afMin_q, afMax_q) &&                  // [RULE_16] [RULE_17]
                  cmpOp(cfg.sdtOp, {24'h000000, dec.sdt},
                        {24'h000000, xlPat_q[7:0]}, {24'h000000, xlPat_q[15:8]}) && // [RULE_18]
                  bitOk(cfg.secMatch, dec.sec) &&                                   // [RULE_19]
                  cmpOp(cfg.vcidOp, {24'h000000, dec.vcid},
                        {24'h000000, xlPat_q[23:16]}, {24'h000000, xlPat_q[31:24]}); // [RULE_20]

    // match sequencer: one strobe per frame at most
    always_comb begin
        state_d = state_q;
        fired_d = fired_q;
        trig_d  = 1'b0;
        lastCause_d = lastCause_q;
        if (dec.sofEdge) begin
            state_d = ST_HEADER;                                    // [RULE_22]
            fired_d = 1'b0;
            if (cfg.trigType == cfm_pkg::frame_start_type) begin
                trig_d  = 1'b1;                                     // [RULE_21]
                fired_d = 1'b1;
            end
        end else if (!fired_q) begin
            if (errHit) begin
                trig_d      = 1'b1;
                fired_d     = 1'b1;
                lastCause_d = errGated;
            end else if (cfg.trigType == cfm_pkg::frame_type_type &&
                         ((dec.errFrame && cfg.frameSel == cfm_pkg::error_frame) ||
                          (dec.ovldFrame && cfg.frameSel == cfm_pkg::overload_frame))) begin
                trig_d  = 1'b1;                                     // [RULE_01]
                fired_d = 1'b1;
                state_d = ST_DONE;
            end else begin
                case (state_q)
                    ST_HEADER: begin
                        if (hdrMode && decPoint) begin
                            state_d = ST_DONE;
                            if (kindOk && idOk) begin
                                if (isFd) begin
                                    state_d = ST_FDCTRL;
                                end else if (dec.kind == cfm_pkg::xl_frame) begin
                                    state_d = ST_XLFIELDS;
                                end else begin
                                    trig_d  = 1'b1;                 // [RULE_22]
                                    fired_d = 1'b1;
                                end
                            end
                        end
                    end
                    ST_FDCTRL: begin
                        if (dec.fdCtrlValid) begin
                            state_d = ST_DONE;
                            trig_d  = fdOk;                         // [RULE_14]
                            fired_d = fdOk;
                        end
                    end
                    ST_XLFIELDS: begin
                        if (dec.xlValid) begin
                            state_d = ST_DONE;
                            trig_d  = xlOk;                         // [RULE_16]
                            fired_d = xlOk;
                        end
                    end
                    ST_IDLE, ST_DONE: ;
                    default: state_d = ST_IDLE;
                endcase
            end
        end
    end

    assign trigCnt_d = trig_d ? trigCnt_q + 16'h0001 : trigCnt_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q     <= ST_IDLE;
            fired_q     <= 1'b0;
            trig_q      <= 1'b0;
            trigCnt_q   <= 16'h0000;
            lastCause_q <= 5'h00;
        end else if (clkEn) begin
            state_q     <= state_d;
            fired_q     <= fired_d;
            trig_q      <= trig_d;
            trigCnt_q   <= trigCnt_d;
            lastCause_q <= lastCause_d;
        end
    end

    assign trigger = trig_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sof_strobe_a: assert property (clkEn && dec.sofEdge &&                  // [RULE_21]
        cfg.trigType == cfm_pkg::frame_start_type |=> trigger)
        else $error("no strobe after frame start");
    strobe_single_a: assert property (trigger && clkEn |=> !trigger) // [RULE_22]
        else $error("trigger strobe lasted more than one cycle");
    err_type_only_a: assert property (cfg.trigType != cfm_pkg::error_condition_type // [RULE_13]
        |-> errGated == '0)
        else $error("error source active outside error type");
    ack_err_a: assert property (clkEn && !fired_q && !dec.sofEdge && dec.ackSlot && // [RULE_10]
        dec.bitValue && cfg.errEnable[2] &&
        cfg.trigType == cfm_pkg::error_condition_type |=> trigger)
        else $error("recessive ack slot did not trigger");
    form_err_a: assert property (clkEn && !fired_q && !dec.sofEdge && dec.formBad && // [RULE_08]
        cfg.errEnable[0] && cfg.trigType == cfm_pkg::error_condition_type
        |=> trigger && lastCause_q[0])
        else $error("form error did not trigger");
    stuff_run_a: assert property (clkEn && stuffHit && !fired_q &&     // [RULE_11]
        cfg.errEnable[3] && cfg.trigType == cfm_pkg::error_condition_type
        |=> trigger && lastCause_q[3])
        else $error("sixth equal bit did not trigger");
    fd_wait_a: assert property (clkEn && state_q == ST_FDCTRL && !dec.fdCtrlValid && // [RULE_14]
        !dec.sofEdge && !errHit && !dec.errFrame && !dec.ovldFrame |=> !trigger)
        else $error("fd frame fired before control bits");
    any_fmt_a: assert property (cfg.trigType == cfm_pkg::ident_type &&      // [RULE_06]
        cfg.idFormat == cfm_pkg::any_identifier_format |-> idOk)
        else $error("any format still compared identifier");
    range_in_a: assert property (cfg.trigType == cfm_pkg::ident_type &&     // [RULE_23]
        cfg.idFormat != cfm_pkg::any_identifier_format && idMin_q <= idMax_q &&
        cfg.idOp == cfm_pkg::in_range_operator && {3'h0, dec.ident} == idMax_q |-> idOk)
        else $error("in-range excluded its upper bound");
    ack_pulse_a: assert property (wb_ack_o && clkEn |=> !wb_ack_o)
        else $error("bus ack held two cycles");

endmodule

// ### cfm_dec_model.sv
// ==========================================================
// frame decoder stand-in feeding the matcher
module cfm_dec_model (
    input  wire logic         ref_clk,
    output cfm_pkg::cfm_dec_t dec
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TOP = $bits(cfm_pkg::cfm_dec_t) - 1;
    initial dec = '0;
    // one-edge pulse, then fields released to inverse so stale data never matches
    task automatic send(input cfm_pkg::cfm_dec_t d);
        cfm_pkg::cfm_dec_t r;
        r = ~d;
        r[TOP -: 15] = '0;
        @(posedge ref_clk);
        dec <= d;
        @(posedge ref_clk);
        dec <= r;
    endtask
endmodule

// ### cfm_trigger_matcher_test.sv
// ==========================================================
// self-checking bench for the trigger matcher
module cfm_trigger_matcher_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TOP = $bits(cfm_pkg::cfm_dec_t) - 1;
    logic              ref_clk = 1'b0;
    logic              rst     = 1'b1;
    logic              cyc     = 1'b0;
    logic              stb     = 1'b0;
    logic              wbWe    = 1'b0;
    logic [7:0]        adr     = 8'h00;
    logic [31:0]       wdat    = 32'h0;
    logic [31:0]       rdat;
    logic              wbAck;
    logic              trig;
    logic [31:0]       q;
    logic [31:0]       lo;
    logic [31:0]       hi;
    logic [31:0]       v;
    cfm_pkg::cfm_dec_t dec;
    integer            seed      = 32'h9b9a2b57;
    int                bad_count = 0;
    int                checks    = 0;
    int                trigs     = 0;
    cfm_pkg::cfm_dec_t fld       = '0;
    cfm_dec_model u_dec (.ref_clk(ref_clk), .dec(dec));
    cfm_trigger_matcher u_dut (.ref_clk(ref_clk), .rst(rst), .clkEn(1'b1), .dec(dec),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wbWe), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(wbAck), .trigger(trig));
    initial forever #10 ref_clk = ~ref_clk;
    task automatic complete_run();
        $display("checks %0d bad %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t reg %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_trig(input logic exp);
        checks++;
        if (trig !== exp) begin
            bad_count++;
            $display("BAD %0t trigger %b want %b", $time, trig, exp);
        end
    endtask
    // classic single cycle, held until ack is seen at an edge
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk);
        {cyc, stb, wbWe, adr, wdat} <= {2'b11, we, a, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        q = rdat;
        {cyc, stb} <= 2'b00;
        if (n >= 50) begin
            bad_count++;
            complete_run();
        end
    endtask
    // pulse one decoder event and look at trigger in the following cycle
    task automatic ev(input int p, input logic [28:0] id, input logic bv, input logic e);
        cfm_pkg::cfm_dec_t d = fld;
        d[TOP - p] = 1'b1;
        d.ident = id;
        d.bitValue = bv;
        d.stuffRegion = 1'b1;
        trigs += e;
        u_dec.send(d);
        @(posedge ref_clk);
        chk_trig(e);
    endtask
    // reference comparison of the eight operators
    function automatic bit cmp_op(int op, longint x, longint l, longint h);
        case (op)
            0: return x == l;
            1: return x != l;
            2: return x < l;
            3: return x <= l;
            4: return x > l;
            5: return x >= l;
            6: return x >= l && x <= h;
            default: return x < l || x > h;
        endcase
    endfunction
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        wb(1'b0, 8'h00, 32'h0);
        chk_reg(q, 32'h0051f000);
        wb(1'b0, 8'h1c, 32'h0);
        chk_reg(q, 32'h0);
        ev(0, 29'h0, 1'b0, 1'b1);
        ev(0, 29'h0, 1'b0, 1'b1);
        $display("test frame start done");
        for (int op = 0; op < 8; op++) begin
            lo = $random(seed) & 32'h3ff;
            hi = lo + ($random(seed) & 32'h3ff);
            wb(1'b1, 8'h04, lo);
            wb(1'b1, 8'h08, hi);
            wb(1'b1, 8'h00, 32'h0011f002 | (op << 7));
            for (int k = 0; k < 4; k++) begin
                v = (k == 0) ? lo : (k == 1) ? hi : (k == 2) ? hi + 1 : $random(seed) & 32'h7ff;
                ev(0, 29'h0, 1'b0, 1'b0);
                ev(1, v[28:0], 1'b0, cmp_op(op, v, lo, hi));
            end
        end
        wb(1'b1, 8'h00, 32'h0011f402);
        ev(0, 29'h0, 1'b0, 1'b0);
        ev(2, lo[28:0], 1'b0, 1'b1);
        $display("test identifier done");
        wb(1'b1, 8'h00, 32'h0011f003);
        ev(0, 29'h0, 1'b0, 1'b0);
        ev(13, 29'h0, 1'b0, 1'b1);
        ev(0, 29'h0, 1'b0, 1'b0);
        ev(14, 29'h0, 1'b0, 1'b1);
        ev(0, 29'h0, 1'b0, 1'b0);
        ev(12, 29'h0, 1'b0, 1'b0);
        ev(12, 29'h0, 1'b1, 1'b1);
        ev(0, 29'h0, 1'b0, 1'b0);
        for (int b = 1; b <= 6; b++) ev(7, 29'h0, 1'b1, b == 6);
        wb(1'b1, 8'h00, 32'h00110003);
        ev(0, 29'h0, 1'b0, 1'b0);
        ev(13, 29'h0, 1'b0, 1'b0);
        $display("test error conditions done");
        // fd control bits, then xl fields, in identifier mode with reset matches
        wb(1'b1, 8'h00, 32'h0051f002);
        v = $random(seed);
        wb(1'b1, 8'h0c, v);
        fld.kind = cfm_pkg::fd_base_frame;
        for (int k = 0; k < 4; k++) begin
            if (k == 2) fld.kind = cfm_pkg::xl_frame;
            fld.brs = v[k];
            fld.esi = !v[k];
            fld.sec = v[k];
            fld.af = v ^ {31'h0, k == 3};
            ev(0, 29'h0, 1'b0, 1'b0);
            ev(1, lo[28:0], 1'b0, 1'b0);
            ev(13, 29'h0, 1'b0, 1'b0);
            if (k < 2) ev(3, lo[28:0], 1'b0, v[k]);
            else ev(4, lo[28:0], 1'b0, k == 2);
        end
        $display("test fd and xl fields done");
        wb(1'b0, 8'h18, 32'h0);
        chk_reg(q, {11'h000, 5'h08, trigs[15:0]});
        complete_run();
    end
endmodule
